// ---- hw/fast_parallel_config_port.sv ----
//   Function
// - Clocks per word: 1 plain, 4 security only, 8 whenever decompression on.
// - 8-bit mode uses data[7:0], 16-bit mode uses data[15:0].
// - Done and status go low within 600 ns of request falling; the code reacts to the request only while the enable bit is set.
// - Status held low 268 to 1506 us, released after request rises.
// - Words captured on a rising load_clock edge.
// - Internal init path enters user mode 175 to 437 us after done.
// - User init clock becomes active four max load_clock periods after done.
// - User init path reaches user mode after 8576 user init clock periods.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module fast_parallel_config_port #(
  parameter int DATA_W         = 32,
  parameter int STATUS_MIN_CYC = fpl_pkg::STATUS_MIN_CYC,
  parameter int USER_MODE_CYC  = fpl_pkg::USER_MODE_CYC,
  parameter int INIT_CLK_EDGES = fpl_pkg::INIT_CLK_EDGES
) (
  // Clock, reset, enable
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Configuration pins
  input  wire logic              config_req_n_i,
  input  wire logic              load_clock_i,
  input  wire logic              user_init_clock_i,
  input  wire logic [DATA_W-1:0] load_data_i,
  output logic                   status_n_o,
  output logic                   status_n_oe_o,
  output logic                   done_o,
  output logic                   user_mode_o,
  // Captured word stream
  output logic      [DATA_W-1:0] word_o,
  output logic                   word_valid_o
);

  // ==========================================================
  // Pin synchronisers
  sync_if #(.W(3))      ctl_s ();
  sync_if #(.W(DATA_W)) dat_s ();

  pin_sync #(.W(3), .INIT(3'h1)) u_ctl_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .pin_i     ({user_init_clock_i, load_clock_i, config_req_n_i}),
    .s         (ctl_s)
  );

  pin_sync #(.W(DATA_W), .INIT('0)) u_dat_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .pin_i     (load_data_i),
    .s         (dat_s)
  );

  logic req_lvl;
  logic req_fall;
  logic lclk_rise;
  logic uclk_rise;

  assign req_lvl   = ctl_s.lvl[0];
  assign req_fall  = ctl_s.fall[0];
  assign lclk_rise = ctl_s.rise[1];
  assign uclk_rise = ctl_s.rise[2];

  // ==========================================================
  // Registers
  fpl_pkg::cfg_state_t state_q;
  logic [5:0]          ctrl_q;
  logic [31:0]         len_q;
  logic [31:0]         wcnt_q;
  logic [DATA_W-1:0]   lastw_q;
  logic                err_q;
  logic [15:0]         tmr_q;
  logic [15:0]         uedge_q;
  logic [2:0]          phase_q;

  logic                wr_en;
  logic                rd_en;
  logic                addr_ok;

  assign wr_en   = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_en   = psel_i & penable_i & ~pready_o;
  assign addr_ok = (paddr_i == fpl_pkg::CTRL_OFS) || (paddr_i == fpl_pkg::LEN_OFS) ||
                   (paddr_i == fpl_pkg::STATUS_OFS) || (paddr_i == fpl_pkg::WCOUNT_OFS) ||
                   (paddr_i == fpl_pkg::LASTW_OFS);

  // ==========================================================
  // Mode decode
  logic [3:0]        ratio;
  logic [2:0]        ratio_m1;
  logic [DATA_W-1:0] data_mask;
  logic              restart;

  always_comb
  begin
    if (ctrl_q[fpl_pkg::CTRL_DECOMP_BIT])
      ratio = fpl_pkg::RATIO_DECOMP;
    else if (ctrl_q[fpl_pkg::CTRL_SECURE_BIT])
      ratio = fpl_pkg::RATIO_SECURE;
    else
      ratio = fpl_pkg::RATIO_PLAIN;
  end

  assign ratio_m1 = 3'(ratio - 4'h1);

  always_comb
  begin
    unique case (ctrl_q[fpl_pkg::CTRL_WIDTH_LSB +: 2])
      fpl_pkg::WIDTH_8:  data_mask = DATA_W'(32'h0000_00FF);
      fpl_pkg::WIDTH_16: data_mask = DATA_W'(32'h0000_FFFF);
      default:           data_mask = '1;
    endcase
  end

  // restart on a new request pulse, only while the enable bit is set
  assign restart = req_fall & ctrl_q[fpl_pkg::CTRL_EN_BIT];

  // ==========================================================
  // APB slave: one wait state on every access
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pready_o  <= rd_en;
      pslverr_o <= rd_en & ~addr_ok;
      if (rd_en && !pwrite_i)
      begin
        unique case (paddr_i)
          fpl_pkg::CTRL_OFS:   prdata_o <= {26'h0, ctrl_q};
          fpl_pkg::LEN_OFS:    prdata_o <= len_q;
          fpl_pkg::STATUS_OFS: prdata_o <= {26'h0, err_q, user_mode_o, done_o, 3'(state_q)};
          fpl_pkg::WCOUNT_OFS: prdata_o <= wcnt_q;
          fpl_pkg::LASTW_OFS:  prdata_o <= 32'(lastw_q);
          default:             prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ctrl_q <= fpl_pkg::CTRL_RST;
      len_q  <= fpl_pkg::LEN_RST;
    end
    else if (ce_i && wr_en)
    begin
      if (paddr_i == fpl_pkg::CTRL_OFS)
        ctrl_q <= pwdata_i[5:0];
      if (paddr_i == fpl_pkg::LEN_OFS)
        len_q <= pwdata_i;
    end
  end

  // sticky error, a new event beats the clear
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      err_q <= 1'b0;
    else if (ce_i)
    begin
      if (restart && state_q == fpl_pkg::ST_LOAD)
        err_q <= 1'b1;
      else if (wr_en && paddr_i == fpl_pkg::STATUS_OFS && pwdata_i[fpl_pkg::STAT_ERR_BIT])
        err_q <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration sequence
  logic        first_edge;
  logic        last_edge;
  logic [31:0] words_now;

  assign first_edge = (phase_q == 3'h0);
  assign last_edge  = (phase_q == ratio_m1);
  assign words_now  = wcnt_q + {31'h0, first_edge};

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state_q      <= fpl_pkg::ST_IDLE;
      tmr_q        <= 16'h0000;
      uedge_q      <= 16'h0000;
      phase_q      <= 3'h0;
      wcnt_q       <= 32'h0000_0000;
      lastw_q      <= '0;
      word_o       <= '0;
      word_valid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      word_valid_o <= 1'b0;
      if (restart)
      begin
        state_q <= fpl_pkg::ST_CLEAR;
        tmr_q   <= 16'h0000;
        uedge_q <= 16'h0000;
        phase_q <= 3'h0;
        wcnt_q  <= 32'h0000_0000;
      end
      else
      begin
        unique case (state_q)
          fpl_pkg::ST_IDLE:
            tmr_q <= 16'h0000;
          fpl_pkg::ST_CLEAR:
          begin
            if (32'(tmr_q) < STATUS_MIN_CYC)
              tmr_q <= tmr_q + 16'h0001;
            // minimum low time, release once request is high
            else if (req_lvl)
              state_q <= fpl_pkg::ST_LOAD;
          end
          fpl_pkg::ST_LOAD:
          begin
            tmr_q <= 16'h0000;
            // act on load_clock rising edges only
            if (lclk_rise)
            begin
              phase_q <= last_edge ? 3'h0 : phase_q + 3'h1;
              if (first_edge)
              begin
                word_o       <= dat_s.lvl & data_mask;
                lastw_q      <= dat_s.lvl & data_mask;
                word_valid_o <= 1'b1;
                wcnt_q       <= words_now;
              end
              // spare edges finish the final word
              if (last_edge && words_now >= len_q)
                state_q <= fpl_pkg::ST_INIT;
            end
          end
          fpl_pkg::ST_INIT:
          begin
            if (ctrl_q[fpl_pkg::CTRL_USRCLK_BIT])
            begin
              if (32'(tmr_q) < fpl_pkg::INITCLK_EN_CYC)
                tmr_q <= tmr_q + 16'h0001;
              else if (32'(uedge_q) >= INIT_CLK_EDGES)
                state_q <= fpl_pkg::ST_USER;
              else if (uclk_rise)
                uedge_q <= uedge_q + 16'h0001;
            end
            else
            begin
              if (32'(tmr_q) >= USER_MODE_CYC - 1)
                state_q <= fpl_pkg::ST_USER;
              else
                tmr_q <= tmr_q + 16'h0001;
            end
          end
          fpl_pkg::ST_USER:
            tmr_q <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin outputs, all registered
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      status_n_o    <= 1'b1;
      status_n_oe_o <= 1'b0;
      done_o        <= 1'b0;
      user_mode_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      status_n_o    <= 1'b0;
      status_n_oe_o <= restart || (state_q == fpl_pkg::ST_CLEAR && !(req_lvl && 32'(tmr_q) >= STATUS_MIN_CYC));
      done_o        <= !restart && (state_q == fpl_pkg::ST_INIT || state_q == fpl_pkg::ST_USER ||
                       (state_q == fpl_pkg::ST_LOAD && lclk_rise && last_edge && words_now >= len_q));
      user_mode_o   <= !restart && state_q == fpl_pkg::ST_USER;
    end
  end

endmodule

// ---- hw/fpl_pkg.sv ----
package fpl_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] LEN_OFS     = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] WCOUNT_OFS  = 8'h0C;
  localparam logic [7:0] LASTW_OFS   = 8'h10;

  // ==========================================================
  // Control and status field positions
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_WIDTH_LSB   = 1;
  localparam int CTRL_DECOMP_BIT  = 3;
  localparam int CTRL_SECURE_BIT  = 4;
  localparam int CTRL_USRCLK_BIT  = 5;
  localparam int STAT_DONE_BIT    = 3;
  localparam int STAT_USER_BIT    = 4;
  localparam int STAT_ERR_BIT     = 5;

  localparam logic [5:0]  CTRL_RST = 6'h05;
  localparam logic [31:0] LEN_RST  = 32'h0000_0001;

  // ==========================================================
  // Bus width modes
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;

  // Clocks per word
  localparam logic [3:0] RATIO_PLAIN  = 4'h1;
  localparam logic [3:0] RATIO_SECURE = 4'h4;
  localparam logic [3:0] RATIO_DECOMP = 4'h8;

  // ==========================================================
  // Timing
  localparam int SYS_PERIOD_NS     = 40;
  localparam int STATUS_MIN_US     = 268;
  localparam int STATUS_MIN_CYC    = (STATUS_MIN_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int USER_MODE_MIN_US  = 175;
  localparam int USER_MODE_CYC     = (USER_MODE_MIN_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int LOAD_CLK_MAX_PER_NS = 10;
  localparam int INITCLK_EN_NS     = 4 * LOAD_CLK_MAX_PER_NS;
  localparam int INITCLK_EN_RAW    = (INITCLK_EN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int INITCLK_EN_CYC    = (INITCLK_EN_RAW < 1) ? 1 : INITCLK_EN_RAW;
  localparam int INIT_CLK_EDGES    = 8576;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLEAR,
    ST_LOAD,
    ST_INIT,
    ST_USER
  } cfg_state_t;

endpackage

// ---- hw/sync_if.sv ----
`timescale 1ns/10ps
interface sync_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// ---- hw/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock, reset, enable
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  // Asynchronous pins
  input  wire logic [W-1:0] pin_i,
  // Synchronised view
  sync_if.src               s
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] dly_q;

  // ==========================================================
  // Two-stage synchroniser, then edge detection on stage two
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
      dly_q  <= INIT;
    end
    else if (ce_i)
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      dly_q  <= sync_q;
    end
  end

  assign s.lvl  = sync_q;
  assign s.rise = sync_q & ~dly_q;
  assign s.fall = ~sync_q & dly_q;

endmodule

// ---- verif/fpl_monitor.sv ----
`timescale 1ns/10ps
module fpl_monitor #(
  parameter int DATA_W         = 32,
  parameter int STATUS_MIN_CYC = 20,
  parameter int USER_MODE_CYC  = 20
) (
  // Clock and reset
  input wire logic              clk_sys_i,
  input wire logic              srst_i,
  input wire logic              ce_i,
  // APB
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [7:0]        paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  // Configuration pins
  input wire logic              config_req_n_i,
  input wire logic              status_n_oe_o,
  input wire logic              done_o,
  input wire logic              user_mode_o,
  input wire logic [DATA_W-1:0] word_o,
  input wire logic              word_valid_o
);
  // ==========
  // Shadow state
  logic [5:0]  ctrl_q;
  logic [15:0] low_q;
  logic [15:0] wait_q;
  logic [31:0] mask;
  logic        wr_ctrl;
  logic        mapped;
  assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && (paddr_i == fpl_pkg::CTRL_OFS);
  assign mapped  = (paddr_i[1:0] == 2'h0) && (paddr_i <= fpl_pkg::LASTW_OFS);
  assign mask    = (ctrl_q[2:1] == fpl_pkg::WIDTH_8) ? 32'h0000_00FF :
                   (ctrl_q[2:1] == fpl_pkg::WIDTH_16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  always_ff @(posedge clk_sys_i)
    ctrl_q <= srst_i ? fpl_pkg::CTRL_RST : (wr_ctrl ? pwdata_i[5:0] : ctrl_q);
  // Cycles with status pulled low
  always_ff @(posedge clk_sys_i)
    low_q <= (srst_i || !status_n_oe_o) ? 16'h0 : low_q + 16'h1;
  // Cycles from done to user mode
  always_ff @(posedge clk_sys_i)
    wait_q <= (srst_i || !done_o || user_mode_o) ? 16'h0 : wait_q + 16'h1;
  // ==========
  // Assertions
  default clocking dc @(posedge clk_sys_i);
  endclocking
  // Design is frozen while the enable is low
  default disable iff (srst_i || !ce_i);
  sequence req_held;
    !config_req_n_i [*4];
  endsequence
  sequence answer_once;
    (pslverr_o == !mapped) ##1 !pready_o;
  endsequence
  req_status_a:
    assert property (ctrl_q[0] && $fell(config_req_n_i) |-> ##[1:15] status_n_oe_o)
    else $error("status not pulled low after request");
  clear_flags_a: assert property (status_n_oe_o |-> !done_o && !user_mode_o)
    else $error("done or user mode high while status low");
  status_min_a: assert property ($fell(status_n_oe_o) |-> low_q >= STATUS_MIN_CYC)
    else $error("status released too early");
  status_keep_a: assert property (req_held ##0 status_n_oe_o |=> status_n_oe_o)
    else $error("status released while request low");
  apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready not one cycle after access");
  apb_answer_a: assert property (pready_o |-> answer_once)
    else $error("wrong error flag or ready too long");
  word_mask_a:
    assert property (word_valid_o |-> (word_o & ~mask[DATA_W-1:0]) == '0 ##1 !word_valid_o)
    else $error("unused data lines reached word");
  user_delay_a:
    assert property ($rose(user_mode_o) && !ctrl_q[5] |-> wait_q inside {[USER_MODE_CYC-1:USER_MODE_CYC+1]})
    else $error("internal init time wrong");
endmodule

bind fast_parallel_config_port fpl_monitor #(
  .DATA_W(DATA_W), .STATUS_MIN_CYC(STATUS_MIN_CYC), .USER_MODE_CYC(USER_MODE_CYC)
) i_mon (
  .clk_sys_i, .srst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
  .config_req_n_i, .status_n_oe_o, .done_o, .user_mode_o, .word_o, .word_valid_o
);

// ---- verif/fpl_host_model.sv ----
`timescale 1ns/10ps
module fpl_host_model #(
  parameter int BLIND_WAIT_NS = 1506000
) (
  // Host pins
  output logic        config_req_n_o,
  output logic        load_clock_o,
  output logic        user_init_clock_o,
  output logic [31:0] load_data_o,
  // Status wire, pulled up
  input  wire logic   status_n_i
);
  // Clocks stand still between frames
  initial
  begin
    config_req_n_o = 1'b1;
    load_clock_o = 1'b0;
    user_init_clock_o = 1'b0;
    load_data_o = 32'h0;
  end
  task automatic request(output bit ok);
    int n;
    ok = 1'b0;
    #5 config_req_n_o = 1'b0;
    #2100 config_req_n_o = 1'b1;
    for (n = 0; n < 2000 && !ok; n++)
      #40 ok = (status_n_i === 1'b1);
    #2000;
  endtask
  // pulse without watching status, then the long gap
  task automatic request_blind();
    #5 config_req_n_o = 1'b0;
    #2100 config_req_n_o = 1'b1;
    #(BLIND_WAIT_NS);
  endtask
  task automatic send(input logic [31:0] w, input int ratio);
    #13 load_data_o = w;
    repeat (ratio)
    begin
      #160 load_clock_o = 1'b1;
      #160 load_clock_o = 1'b0;
    end
    // Released lines never keep the old word
    load_data_o = ~w;
  endtask
  task automatic init_clock(input int n);
    repeat (n)
    begin
      #107 user_init_clock_o = 1'b1;
      #107 user_init_clock_o = 1'b0;
    end
  endtask
endmodule

// ---- verif/fast_parallel_config_port_tb.sv ----
`timescale 1ns/10ps
module fast_parallel_config_port_tb;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, ldata, word, exp_w = 32'h0, mask = 32'h0;
  logic        pready, pslverr, req_n, lclk, uclk, stat_n, stat_oe, done, umode, wvalid, stat_w;
  int          err_count = 0, cmp_count = 0;
  logic [5:0]  ctl [4] = '{6'h05, 6'h13, 6'h09, 6'h1D};
  int          rat [4] = '{1, 4, 8, 8};
  always #20 clk = ~clk;
  assign stat_w = stat_oe ? stat_n : 1'b1;
  fast_parallel_config_port #(.STATUS_MIN_CYC(20), .USER_MODE_CYC(20), .INIT_CLK_EDGES(8)) i_dut (
    .clk_sys_i(clk), .srst_i(srst), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .config_req_n_i(req_n), .load_clock_i(lclk), .user_init_clock_i(uclk),
    .load_data_i(ldata), .status_n_o(stat_n), .status_n_oe_o(stat_oe), .done_o(done),
    .user_mode_o(umode), .word_o(word), .word_valid_o(wvalid)
  );
  // Blind gap scaled to the shortened status time
  fpl_host_model #(.BLIND_WAIT_NS(4000)) i_host (
    .config_req_n_o(req_n), .load_clock_o(lclk), .user_init_clock_o(uclk), .load_data_o(ldata),
    .status_n_i(stat_w)
  );
  // ==========
  // Tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang();
    err_count++;
    final_report();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask
  task automatic wait_sig(input bit um);
    int n;
    for (n = 0; n < 5000; n++)
    begin
      @(posedge clk);
      if ((um ? umode : done) === 1'b1)
        break;
    end
    if (n == 5000)
      hang();
  endtask
  task automatic load(input logic [5:0] c, input int ratio, input int len);
    bit ok;
    int i;
    mask = (c[2:1] == 2'h0) ? 32'h0000_00FF : (c[2:1] == 2'h1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    exp_w = 32'hA5C3_9F10;
    wr(fpl_pkg::CTRL_OFS, {26'h0, c});
    wr(fpl_pkg::LEN_OFS, 32'(len));
    i_host.request(ok);
    chk("status release", 32'h1, 32'(ok));
    for (i = 0; i < len; i++)
      i_host.send(32'hA5C3_9F10 + 32'(i), ratio);
    wait_sig(1'b0);
    rdc("word count", fpl_pkg::WCOUNT_OFS, 32'(len));
  endtask
  always @(posedge clk)
  begin
    if (wvalid === 1'b1)
    begin
      chk("word", exp_w & mask, word);
      exp_w = exp_w + 32'h1;
    end
  end
  // ==========
  // Sequence
  initial
  begin
    logic [31:0] r;
    logic        e;
    bit          ok;
    int          i;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rdc("ctrl reset", fpl_pkg::CTRL_OFS, 32'(fpl_pkg::CTRL_RST));
    rdc("len reset", fpl_pkg::LEN_OFS, fpl_pkg::LEN_RST);
    wr(fpl_pkg::WCOUNT_OFS, 32'hFFFF_FFFF);
    rdc("wcount read only", fpl_pkg::WCOUNT_OFS, 32'h0);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    // Enable low: a request pulse must leave no trace
    ce <= 1'b0;
    i_host.request(ok);
    @(posedge clk);
    ce <= 1'b1;
    chk("frozen status", 32'h1, 32'(ok));
    rdc("frozen state", fpl_pkg::STATUS_OFS, 32'h0);
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      load(ctl[i], rat[i], 2);
      rdc("last word", fpl_pkg::LASTW_OFS, 32'hA5C3_9F11 & mask);
      wait_sig(1'b1);
      rdc("status user", fpl_pkg::STATUS_OFS, 32'h1C);
    end
    $display("test modes done");
    load(6'h25, 1, 1);
    i_host.init_clock(7);
    repeat (8) @(posedge clk);
    chk("user mode early", 32'h0, 32'(umode));
    i_host.init_clock(1);
    repeat (8) @(posedge clk);
    chk("user mode", 32'h1, 32'(umode));
    $display("test init clock done");
    wr(fpl_pkg::LEN_OFS, 32'h2);
    i_host.request(ok);
    i_host.send(exp_w, 1);
    i_host.request_blind();
    rdc("error flag", fpl_pkg::STATUS_OFS, 32'h22);
    wr(fpl_pkg::STATUS_OFS, 32'h20);
    rdc("error clear", fpl_pkg::STATUS_OFS, 32'h02);
    $display("test restart done");
    wr(fpl_pkg::CTRL_OFS, 32'h04);
    i_host.request(ok);
    rdc("request refused", fpl_pkg::STATUS_OFS, 32'h02);
    $display("test disabled done");
    final_report();
  end
endmodule
